// ==== bnac_pkg.sv ====
package bnac_pkg;
  // ---------------------------------------------------------------
  // storage geometry
  // ---------------------------------------------------------------
  localparam int NVM_DEPTH = 32;
  localparam int NVM_AW = 5;
  // ---------------------------------------------------------------
  // special-function register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_OFS = 8'h30;
  localparam logic [7:0] DATA_OFS = 8'h31;
  localparam logic [7:0] INTC_OFS = 8'h32;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic CTRL_BANK = 1'b1;
  localparam int CTRL_WPERM_BIT = 3;
  localparam int CTRL_WTRIG_BIT = 2;
  localparam int CTRL_RPERM_BIT = 1;
  localparam int CTRL_RTRIG_BIT = 0;
  localparam int INTC_GIE_BIT = 0;
  localparam int INTC_IEN_BIT = 1;
  localparam int INTC_FLAG_BIT = 2;
  localparam logic [4:0] ADDR_RST = 5'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_PERM_W = 8'h08;
  localparam logic [7:0] CTRL_TRIG_W = 8'h0C;
  localparam logic [7:0] CTRL_PERM_R = 8'h02;
  localparam logic [7:0] CTRL_TRIG_R = 8'h03;
  localparam logic [7:0] CTRL_CLEAR = 8'h00;
  localparam logic [7:0] POLL_NONE = 8'h00;
  localparam logic [7:0] POLL_WTRIG = 8'h04;
  localparam logic [7:0] POLL_RTRIG = 8'h01;
  // ---------------------------------------------------------------
  // timing, in system-clock cycles at 25 MHz, write length in timer ticks
  // ---------------------------------------------------------------
  localparam int RD_CYCLES = 4;
  localparam int TMR_DIV = 8;
  localparam int WR_TICKS = 16;
  localparam logic [2:0] RD_LOAD = 3'(RD_CYCLES - 1);
  localparam logic [2:0] DIV_LAST = 3'(TMR_DIV - 1);
  localparam logic [4:0] TICK_LAST = 5'(WR_TICKS - 1);
  // ---------------------------------------------------------------
  // controller registers on the AHB-Lite side
  // ---------------------------------------------------------------
  localparam logic [7:0] HCMD_OFS = 8'h00;
  localparam logic [7:0] HSTAT_OFS = 8'h04;
  localparam logic [7:0] HCFG_OFS = 8'h08;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_DIR_BIT = 1;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_IRQ_BIT = 2;
  localparam int STAT_RDATA_LSB = 8;
  localparam int CFG_IEN_BIT = 0;
  localparam int CFG_STKFULL_BIT = 1;
  localparam logic [2:0] WR_LAST = 3'd7;
  localparam logic [2:0] RD_LAST = 3'd5;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } bnac_state_e;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_ACC = 4'b0010,
    H_WAIT = 4'b0100,
    H_CHECK = 4'b1000
  } bnac_hstate_e;
  typedef struct packed {
    logic last;
    logic rd;
    logic [7:0] mask;
    logic bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bnac_step_s;
endpackage

// ==== bnac_if.sv ====
`timescale 1ns/1ps
interface bnac_if;
  logic sfr_sel;
  logic sfr_wr;
  logic bank_select;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic irq_call;
  logic stack_full;
  modport device (
    input sfr_sel,
    input sfr_wr,
    input bank_select,
    input sfr_addr,
    input sfr_wdata,
    input stack_full,
    output sfr_rdata,
    output irq_call
  );
  modport core (
    output sfr_sel,
    output sfr_wr,
    output bank_select,
    output sfr_addr,
    output sfr_wdata,
    output stack_full,
    input sfr_rdata,
    input irq_call
  );
endinterface

// ==== bnac_device.sv ====
// Behaviour
// - thirty-two bytes, reached only through registers
// - single-byte access; data regs bank zero (decoded here in either bank)
// - control register at 40H in bank one
// - address field bits 4-0, upper bits zero
// - control bits 3..0, upper bits read zero
// - no array write without write permit
// - write trigger starts cycle, cleared at end
// - write trigger needs permit set beforehand
// - no array read without read permit
// - read trigger starts read, cleared at end
// - read trigger needs permit set beforehand
// - never set both triggers together
// - read byte held until next operation
// - read: permit, address, trigger, poll, take
// - write trigger right after write permit
// - drop global enable around write start
// - write timed by asynchronous internal timer
// - power-on clears write permit
// - write end sets storage request flag
// - call needs both enables, stack not full
// - service clears flag and global enable
// - no low-power mode during pending cycle
`timescale 1ns/1ps
module bnac_device
  import bnac_pkg::*;
(
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // core side
  bnac_if.device sfr,
  // status
  output logic cycle_busy
);
  // ---------------------------------------------------------------
  // storage and registers
  // ---------------------------------------------------------------
  logic [7:0] mem_r [NVM_DEPTH];
  logic [NVM_AW-1:0] addr_r;
  logic [7:0] data_r;
  logic [NVM_AW-1:0] op_addr_r;
  logic [7:0] op_data_r;
  logic wperm_r;
  logic wtrig_r;
  logic rperm_r;
  logic rtrig_r;
  logic gie_r;
  logic ien_r;
  logic flag_r;
  bnac_state_e state_r;
  logic [2:0] rd_cnt_r;
  logic [2:0] div_r;
  logic tmr_run_r;
  logic [4:0] tick_r;
  logic done_tgl_r;
  logic done_s1_r;
  logic done_s2_r;
  logic done_s3_r;
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic hit_addr;
  logic hit_data;
  logic hit_intc;
  logic hit_ctrl;
  logic idle;
  logic start_wr;
  logic start_rd;
  logic rd_done;
  logic wr_done;
  logic tick;
  logic service;
  assign wr_acc = sfr.sfr_sel & sfr.sfr_wr;
  assign rd_acc = sfr.sfr_sel & ~sfr.sfr_wr;
  assign hit_addr = (sfr.sfr_addr == ADDR_OFS);
  assign hit_data = (sfr.sfr_addr == DATA_OFS);
  assign hit_intc = (sfr.sfr_addr == INTC_OFS);
  assign hit_ctrl = (sfr.sfr_addr == CTRL_OFS) && (sfr.bank_select == CTRL_BANK);
  assign idle = (state_r == ST_IDLE);
  // permit must already stand; a write trigger wins over a read one
  assign start_wr = wr_acc & hit_ctrl & idle & wperm_r & sfr.sfr_wdata[CTRL_WTRIG_BIT];
  assign start_rd = wr_acc & hit_ctrl & idle & rperm_r & sfr.sfr_wdata[CTRL_RTRIG_BIT]
                    & ~sfr.sfr_wdata[CTRL_WTRIG_BIT];
  assign rd_done = (state_r == ST_READ) && (rd_cnt_r == 3'h0);
  assign wr_done = (state_r == ST_WRITE) && (done_s2_r ^ done_s3_r);
  assign tick = (div_r == DIV_LAST);
  assign service = flag_r & ien_r & gie_r & ~sfr.stack_full & ~sfr.irq_call;
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_wr) begin
            state_r <= ST_WRITE;
          end else if (start_rd) begin
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (rd_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (wr_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_busy <= 1'b0;
    end else begin
      cycle_busy <= start_wr | start_rd | (~idle & ~rd_done & ~wr_done);
    end
  end
  // ---------------------------------------------------------------
  // read latency counter
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_r <= 3'h0;
    end else if (start_rd) begin
      rd_cnt_r <= RD_LOAD;
    end else if (rd_cnt_r != 3'h0) begin
      rd_cnt_r <= rd_cnt_r - 3'h1;
    end
  end
  // ---------------------------------------------------------------
  // free-running write timer, not aligned to the access
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 3'h0;
    end else if (tick) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_run_r <= 1'b0;
      tick_r <= 5'h00;
      done_tgl_r <= 1'b0;
    end else if (start_wr) begin
      tmr_run_r <= 1'b1;
      tick_r <= 5'h00;
    end else if (tmr_run_r && tick) begin
      if (tick_r == TICK_LAST) begin
        tmr_run_r <= 1'b0;
        done_tgl_r <= ~done_tgl_r;
      end else begin
        tick_r <= tick_r + 5'h01;
      end
    end
  end
  // completion toggle crosses into the core's timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
    end else begin
      done_s1_r <= done_tgl_r;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
    end
  end
  // ---------------------------------------------------------------
  // storage array
  // ---------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (wr_done && wperm_r) begin
      mem_r[op_addr_r] <= op_data_r;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_addr_r <= ADDR_RST;
      op_data_r <= DATA_RST;
    end else if (start_wr || start_rd) begin
      op_addr_r <= addr_r;
      op_data_r <= data_r;
    end
  end
  // ---------------------------------------------------------------
  // address and data registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= ADDR_RST;
    end else if (wr_acc && hit_addr) begin
      addr_r <= sfr.sfr_wdata[NVM_AW-1:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= DATA_RST;
    end else if (rd_done && rperm_r) begin
      data_r <= mem_r[op_addr_r];
    end else if (wr_acc && hit_data) begin
      data_r <= sfr.sfr_wdata;
    end
  end
  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wperm_r <= 1'b0;
      rperm_r <= 1'b0;
    end else if (wr_acc && hit_ctrl) begin
      wperm_r <= sfr.sfr_wdata[CTRL_WPERM_BIT];
      rperm_r <= sfr.sfr_wdata[CTRL_RPERM_BIT];
    end
  end
  // triggers ignore software clears while their cycle runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wtrig_r <= 1'b0;
      rtrig_r <= 1'b0;
    end else begin
      if (start_wr) begin
        wtrig_r <= 1'b1;
      end else if (wr_done) begin
        wtrig_r <= 1'b0;
      end
      if (start_rd) begin
        rtrig_r <= 1'b1;
      end else if (rd_done) begin
        rtrig_r <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // storage interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
    end else if (wr_done) begin
      flag_r <= 1'b1;
    end else if (service) begin
      flag_r <= 1'b0;
    end else if (wr_acc && hit_intc) begin
      flag_r <= sfr.sfr_wdata[INTC_FLAG_BIT];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (wr_acc && hit_intc) begin
      gie_r <= sfr.sfr_wdata[INTC_GIE_BIT];
      ien_r <= sfr.sfr_wdata[INTC_IEN_BIT];
    end else if (service) begin
      gie_r <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sfr.irq_call <= 1'b0;
    end else begin
      sfr.irq_call <= service;
    end
  end
  // ---------------------------------------------------------------
  // read-back, unmapped locations read zero
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sfr.sfr_rdata <= 8'h00;
    end else if (rd_acc) begin
      if (hit_addr) begin
        sfr.sfr_rdata <= {3'h0, addr_r};
      end else if (hit_data) begin
        sfr.sfr_rdata <= data_r;
      end else if (hit_intc) begin
        sfr.sfr_rdata <= {5'h00, flag_r, ien_r, gie_r};
      end else if (hit_ctrl) begin
        sfr.sfr_rdata <= {4'h0, wperm_r, wtrig_r, rperm_r, rtrig_r};
      end else begin
        sfr.sfr_rdata <= 8'h00;
      end
    end
  end
endmodule

// ==== bnac_host.sv ====
`timescale 1ns/1ps
module bnac_host
  import bnac_pkg::*;
(
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // ahb-lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // device side
  bnac_if.core sfr
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  bnac_hstate_e state_r;
  logic [2:0] step_r;
  logic dir_r;
  logic [4:0] cmd_addr_r;
  logic [7:0] cmd_data_r;
  logic [7:0] rdata_r;
  logic done_r;
  logic irq_seen_r;
  logic ien_r;
  logic stk_r;
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic addr_ph;
  logic go;
  bnac_step_s cur;
  assign addr_ph = hsel & hready & htrans[1];
  assign go = wr_pend_r && (wr_ofs_r == HCMD_OFS) && (state_r == H_IDLE)
              && hwdata[CMD_GO_BIT];
  // ---------------------------------------------------------------
  // software sequences, one access per step
  // ---------------------------------------------------------------
  function automatic bnac_step_s step_fn(input logic wr, input logic [2:0] s,
                                          input logic [4:0] a, input logic [7:0] d,
                                          input logic ie);
    bnac_step_s t;
    t = '{last: 1'b0, rd: 1'b0, mask: POLL_NONE, bank: 1'b0, addr: CTRL_OFS,
          wdata: CTRL_CLEAR};
    if (wr) begin
      unique case (s)
        3'd0: begin t.addr = INTC_OFS; t.wdata = {6'h00, ie, 1'b0}; end
        3'd1: begin t.addr = ADDR_OFS; t.wdata = {3'h0, a}; end
        3'd2: begin t.addr = DATA_OFS; t.wdata = d; end
        3'd3: begin t.bank = CTRL_BANK; t.wdata = CTRL_PERM_W; end
        3'd4: begin t.bank = CTRL_BANK; t.wdata = CTRL_TRIG_W; end
        3'd5: begin t.addr = INTC_OFS; t.wdata = {6'h00, ie, 1'b1}; end
        3'd6: begin t.bank = CTRL_BANK; t.rd = 1'b1; t.mask = POLL_WTRIG; end
        default: begin t.bank = CTRL_BANK; t.last = 1'b1; end
      endcase
    end else begin
      unique case (s)
        3'd0: begin t.bank = CTRL_BANK; t.wdata = CTRL_PERM_R; end
        3'd1: begin t.addr = ADDR_OFS; t.wdata = {3'h0, a}; end
        3'd2: begin t.bank = CTRL_BANK; t.wdata = CTRL_TRIG_R; end
        3'd3: begin t.bank = CTRL_BANK; t.rd = 1'b1; t.mask = POLL_RTRIG; end
        3'd4: begin t.bank = CTRL_BANK; end
        default: begin t.addr = DATA_OFS; t.rd = 1'b1; t.last = 1'b1; end
      endcase
    end
    return t;
  endfunction
  assign cur = step_fn(dir_r, step_r, cmd_addr_r, cmd_data_r, ien_r);
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= H_IDLE;
      step_r <= 3'h0;
      rdata_r <= 8'h00;
    end else begin
      unique case (state_r)
        H_IDLE: begin // no power-down hook, a cycle always runs out
          if (go) begin
            state_r <= H_ACC;
            step_r <= 3'h0;
          end
        end
        H_ACC: begin
          if (cur.rd) begin
            state_r <= H_WAIT;
          end else if (cur.last) begin
            state_r <= H_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
          end
        end
        H_WAIT: begin
          state_r <= H_CHECK;
        end
        H_CHECK: begin
          if ((sfr.sfr_rdata & cur.mask) != 8'h00) begin
            state_r <= H_ACC;
          end else if (cur.last) begin
            rdata_r <= sfr.sfr_rdata;
            state_r <= H_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
            state_r <= H_ACC;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sfr.sfr_sel <= 1'b0;
      sfr.sfr_wr <= 1'b0;
      sfr.bank_select <= 1'b0;
      sfr.sfr_addr <= 8'h00;
      sfr.sfr_wdata <= 8'h00;
    end else begin
      sfr.sfr_sel <= (state_r == H_ACC);
      if (state_r == H_ACC) begin
        sfr.sfr_wr <= ~cur.rd;
        sfr.bank_select <= cur.bank;
        sfr.sfr_addr <= cur.addr;
        sfr.sfr_wdata <= cur.wdata;
      end else if (state_r == H_IDLE) begin
        sfr.bank_select <= 1'b0;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sfr.stack_full <= 1'b0;
    end else begin
      sfr.stack_full <= stk_r;
    end
  end
  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph & hwrite;
      wr_ofs_r <= haddr[7:0];
      if (addr_ph && !hwrite) begin
        unique case (haddr[7:0])
          HCMD_OFS: hrdata <= {8'h00, cmd_data_r, 3'h0, cmd_addr_r, 6'h00, dir_r, 1'b0};
          HSTAT_OFS: hrdata <= {16'h0000, rdata_r, 5'h00, irq_seen_r, done_r,
                                state_r != H_IDLE};
          HCFG_OFS: hrdata <= {30'h0000_0000, stk_r, ien_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= 1'b0;
      cmd_addr_r <= 5'h00;
      cmd_data_r <= 8'h00;
      ien_r <= 1'b0;
      stk_r <= 1'b0;
    end else begin
      if (go) begin
        dir_r <= hwdata[CMD_DIR_BIT];
        cmd_addr_r <= hwdata[CMD_ADDR_LSB +: 5];
        cmd_data_r <= hwdata[CMD_DATA_LSB +: 8];
      end
      if (wr_pend_r && wr_ofs_r == HCFG_OFS) begin
        ien_r <= hwdata[CFG_IEN_BIT];
        stk_r <= hwdata[CFG_STKFULL_BIT];
      end
    end
  end
  // sticky status, write one to clear, a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
      irq_seen_r <= 1'b0;
    end else begin
      if ((state_r == H_ACC && cur.last && !cur.rd) || (state_r == H_CHECK && cur.last
          && (sfr.sfr_rdata & cur.mask) == 8'h00)) begin
        done_r <= 1'b1;
      end else if (wr_pend_r && wr_ofs_r == HSTAT_OFS && hwdata[STAT_DONE_BIT]) begin
        done_r <= 1'b0;
      end
      if (sfr.irq_call) begin
        irq_seen_r <= 1'b1;
      end else if (wr_pend_r && wr_ofs_r == HSTAT_OFS && hwdata[STAT_IRQ_BIT]) begin
        irq_seen_r <= 1'b0;
      end
    end
  end
endmodule

// ==== bnac_properties.sv ====
`timescale 1ns/1ps
module bnac_properties
  import bnac_pkg::*;
(
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // core to device
  input logic sfr_sel,
  input logic sfr_wr,
  input logic bank_select,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_wdata,
  input logic stack_full,
  // device to core
  input logic [7:0] sfr_rdata,
  input logic irq_call
);
  // ---------------------------------------------------------------
  // decodes and helper state
  // ---------------------------------------------------------------
  logic rd, ctrl_rd, ctrl_wr, wperm_set_r;
  assign rd = sfr_sel && !sfr_wr;
  assign ctrl_rd = rd && sfr_addr == CTRL_OFS && bank_select == CTRL_BANK;
  assign ctrl_wr = sfr_sel && sfr_wr && sfr_addr == CTRL_OFS && bank_select == CTRL_BANK;
  // remembers whether software ever asked for write permit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wperm_set_r <= 1'b0;
    end else if (ctrl_wr && sfr_wdata[CTRL_WPERM_BIT]) begin
      wperm_set_r <= 1'b1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  irq_pulse_a: assert property (irq_call |=> !irq_call)
    else $error("service call longer than one cycle");
  irq_stack_a: assert property (irq_call |-> !$past(stack_full))
    else $error("service call while stack full");
  ctrl_upper_a: assert property (ctrl_rd |=> sfr_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  addr_upper_a: assert property (rd && sfr_addr == ADDR_OFS |=> sfr_rdata[7:5] == 3'h0)
    else $error("address upper bits not zero");
  rdata_hold_a: assert property (!rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  bank_zero_a: assert property (rd && sfr_addr == CTRL_OFS && !bank_select |=> sfr_rdata == 8'h00)
    else $error("control reachable in bank zero");
  trig_pair_a: assert property (ctrl_rd |=> !(sfr_rdata[CTRL_WTRIG_BIT] && sfr_rdata[CTRL_RTRIG_BIT]))
    else $error("both triggers set");
  wperm_por_a: assert property (ctrl_rd && !wperm_set_r |=> sfr_rdata[3:2] == 2'b00)
    else $error("write permit or trigger set without software");
  cover property (irq_call);
  cover property (ctrl_wr && sfr_wdata == CTRL_TRIG_W);
  cover property (ctrl_wr && sfr_wdata == CTRL_TRIG_R);
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
  import bnac_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, s;
  logic [1:0] htrans;
  logic busy;
  int n_errors = 0, n_compared = 0, cyc = 0;
  bnac_if sfr_bus();
  bnac_device i_bnac_device(.hclk(hclk), .hresetn(hresetn), .sfr(sfr_bus), .cycle_busy(busy));
  bnac_host i_bnac_host(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sfr(sfr_bus));
  bnac_properties i_bnac_properties(.hclk(hclk), .hresetn(hresetn),
    .sfr_sel(sfr_bus.sfr_sel), .sfr_wr(sfr_bus.sfr_wr), .bank_select(sfr_bus.bank_select),
    .sfr_addr(sfr_bus.sfr_addr), .sfr_wdata(sfr_bus.sfr_wdata),
    .stack_full(sfr_bus.stack_full), .sfr_rdata(sfr_bus.sfr_rdata),
    .irq_call(sfr_bus.irq_call));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  // one storage access through the command register, returns status
  task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
    int t0;
    logic seen;
    seen = 1'b0;
    ahb(1'b1, 32'h4, 32'h6, s);
    t0 = cyc;
    ahb(1'b1, 32'h0, {8'h00, d, 3'h0, a, 6'h00, w, 1'b1}, s);
    // fresh status, never the stale read data of an earlier transfer
    ahb(1'b0, 32'h4, 32'h0, s);
    for (int i = 0; i < 300 && s[1] !== 1'b1; i++) begin
      ahb(1'b0, 32'h4, 32'h0, s);
      seen |= busy;
    end
    chk("done", 32'h1, {31'h0, s[1]});
    chk("busy after op", 32'h0, {31'h0, busy});
    if (w) chk("write long", 32'h1,
               {31'h0, (cyc - t0) >= TMR_DIV * (WR_TICKS - 1) + 1});
    if (w) chk("busy in write", 32'h1, {31'h0, seen});
  endtask
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    ahb(1'b0, 32'h4, 32'h0, s);
    chk("status after reset", 32'h0, {29'h0, s[2:0]});
    ahb(1'b0, 32'h8, 32'h0, s);
    chk("config after reset", 32'h0, s);
    $display("test reset done");
  endtask
  task automatic t_data();
    logic [4:0] ad[2] = '{5'h00, 5'h1F};
    logic [7:0] dt[2] = '{8'h5A, 8'hA5};
    for (int i = 0; i < 2; i++) op(1'b1, ad[i], dt[i]);
    for (int i = 0; i < 2; i++) begin
      op(1'b0, ad[i], 8'h00);
      chk("read byte", {24'h0, dt[i]}, {24'h0, s[15:8]});
      chk("no irq", 32'h0, {31'h0, s[2]});
    end
    $display("test data done");
  endtask
  task automatic t_irq();
    ahb(1'b1, 32'h8, 32'h1, s);
    op(1'b1, 5'h03, 8'h3C);
    chk("irq taken", 32'h1, {31'h0, s[2]});
    ahb(1'b1, 32'h8, 32'h3, s);
    op(1'b1, 5'h04, 8'hC3);
    chk("irq blocked", 32'h0, {31'h0, s[2]});
    $display("test irq done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_data();
    t_irq();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    test_done();
  end
endmodule
